//--- src/pjm_regs.svh
// Constants for the paper path jam monitor
`ifndef PJM_REGS_SVH
`define PJM_REGS_SVH
`define PJM_WIN_W        16
`define PJM_WIN_DEFAULT  16'h0100
`define PJM_CODE_NONE    16'h0000
`define PJM_C_ENT_LATE   16'h1011
`define PJM_C_SIGA_LATE  16'h1012
`define PJM_C_SIGB_LATE  16'h1013
`define PJM_C_TIM_LATE   16'h1014
`define PJM_C_TRAY_LATE  16'h1015
`define PJM_C_SUBG_LATE  16'h1016
`define PJM_C_CPA_LATE   16'h1017
`define PJM_C_CPB_LATE   16'h1018
`define PJM_C_HEX_LATE   16'h1019
`define PJM_C_REG_LATE   16'h101A
`define PJM_C_REGSW_LATE 16'h101B
`define PJM_C_SMS_LATE   16'h101C
`define PJM_C_SML_LATE   16'h101D
`define PJM_C_INVA_LATE  16'h1068
`define PJM_C_INVB_LATE  16'h106A
`define PJM_C_ENT_LAG    16'h1121
`define PJM_C_SIGA_LAG   16'h1122
`define PJM_C_SIGB_LAG   16'h1123
`define PJM_C_TIM_LAG    16'h1124
`define PJM_C_TRAY_LAG   16'h1125
`define PJM_C_CPA_LAG    16'h1127
`define PJM_C_CPB_LAG    16'h1128
`define PJM_C_HEX_LAG    16'h1129
`define PJM_C_REG_LAG    16'h112A
`define PJM_C_REGSW_LAG  16'h112B
`define PJM_C_SMS_LAG    16'h112C
`define PJM_C_SML_LAG    16'h112D
`define PJM_C_INVA_LAG   16'h1169
`define PJM_C_INVB_LAG   16'h116B
`define PJM_C_DOUBLE     16'h1200
`define PJM_C_POWERON    16'h1300
`define PJM_C_DOOR       16'h1400
`define PJM_C_RESIDUE    16'h1700
`define PJM_C_OVERFLOW   16'h1FA0
`define PJM_C_TOO_FEW    16'h1FA1
`define PJM_C_TRIM_WIDE  16'h1FA2
`define PJM_C_BOOK_LONG  16'h1FA3
`define PJM_C_SIZE       16'h1FA5
`define PJM_SHEETS_MAX   8'd200
`define PJM_SHEETS_MIN   8'd9
`define PJM_TRIM_MAX_MM  8'd40
`define PJM_LEN_MAX_MM   9'd216
`define PJM_NUM_STAGE    17
`define PJM_NUM_PATH     9
`endif

//--- src/pjm_pkg.sv
// Types for the paper path jam monitor
package pjm_pkg;
  typedef logic [15:0] pjm_code_t;
  typedef logic [15:0] pjm_win_t;
  typedef enum logic [3:0] {
    PJM_ST_POWERUP = 4'h1,
    PJM_ST_RUN     = 4'h2,
    PJM_ST_HALT    = 4'h4,
    PJM_ST_RECHECK = 4'h8
  } pjm_state_t;
endpackage

//--- src/pjm_edge_stage.sv
// One monitored sensor stage: arrival and departure windows
`timescale 1ns/1ps
`include "pjm_regs.svh"
module pjm_edge_stage (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             start,
  input  wire logic             sensor,
  input  wire pjm_pkg::pjm_win_t arrive_win,
  input  wire pjm_pkg::pjm_win_t leave_win,
  output logic                  late_jam,
  output logic                  lag_jam
);
  import pjm_pkg::*;

  logic     sensor_reg;
  logic     wait_le_reg;
  logic     wait_te_reg;
  pjm_win_t count_reg;
  logic     rise;
  logic     fall;

  assign rise = sensor & ~sensor_reg;
  assign fall = ~sensor & sensor_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sensor_reg <= 1'b0;
    end else begin
      sensor_reg <= sensor;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_le_reg <= 1'b0;
      wait_te_reg <= 1'b0;
      count_reg   <= '0;
      late_jam    <= 1'b0;
      lag_jam     <= 1'b0;
    end else begin
      late_jam <= 1'b0;
      lag_jam  <= 1'b0;
      if (!enable) begin
        wait_le_reg <= 1'b0;
        wait_te_reg <= 1'b0;
      end else if (wait_te_reg) begin
        if (fall) begin
          wait_te_reg <= 1'b0;
        end else if (count_reg == '0) begin
          lag_jam     <= 1'b1;               // Sheet stopped
          wait_te_reg <= 1'b0;
        end else begin
          count_reg <= count_reg - 16'h0001;
        end
      end else if (wait_le_reg) begin
        if (rise) begin
          wait_le_reg <= 1'b0;
          wait_te_reg <= 1'b1;
          count_reg   <= leave_win;
        end else if (count_reg == '0) begin
          late_jam    <= 1'b1;               // Sheet never arrived
          wait_le_reg <= 1'b0;
        end else begin
          count_reg <= count_reg - 16'h0001;
        end
      end else if (start) begin
        wait_le_reg <= 1'b1;
        count_reg   <= arrive_win;
      end
    end
  end

  late_window_a: assert property (@(posedge clock) disable iff (!rst_n)
    late_jam |-> $past(enable)) else $error("late jam while disabled");
endmodule // pjm_edge_stage

//--- src/pjm_jam_monitor.sv
// Paper path jam monitor top
`timescale 1ns/1ps
`include "pjm_regs.svh"
module pjm_jam_monitor (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              sheet_exit,
  input  wire logic              entrance_edge_sensor,
  input  wire logic              signature_path_sensor_a,
  input  wire logic              signature_path_sensor_b,
  input  wire logic              timing_edge_sensor,
  input  wire logic              tray_empty_sensor,
  input  wire logic              sub_grip_transfer,
  input  wire logic              sub_grip_sheet_sensor,
  input  wire logic              cover_path_sensor_a,
  input  wire logic              cover_path_sensor_b,
  input  wire logic              horizontal_exit_sensor,
  input  wire logic              cover_registration_sensor,
  input  wire logic              switchback,
  input  wire logic              side_reg_small,
  input  wire logic              side_reg_large,
  input  wire logic              cover_side_sensor_small,
  input  wire logic              cover_side_sensor_large,
  input  wire logic              inserter_transport_sensor,
  input  wire logic              inserter_vertical_sensor_a,
  input  wire logic              inserter_vertical_sensor_b,
  input  wire logic              top_cover_open_sensor,
  input  wire logic              delivery_active,
  input  wire logic              left_door_interlock,
  input  wire logic              right_front_door_interlock,
  input  wire logic              stacking_active,
  input  wire logic              stacking_overflow_sensor,
  input  wire logic              job_load,
  input  wire logic [7:0]        job_sheets,
  input  wire logic [7:0]        job_trim_mm,
  input  wire logic [8:0]        job_length_mm,
  input  wire logic              size_mismatch,
  input  wire logic              jam_clear,
  input  wire pjm_pkg::pjm_win_t arrive_win [`PJM_NUM_STAGE],
  input  wire pjm_pkg::pjm_win_t leave_win [`PJM_NUM_STAGE],
  output pjm_pkg::pjm_code_t     jam_code,
  output logic                   jam_valid,
  output logic                   binder_halt,
  output logic                   sheet_fed
);
  import pjm_pkg::*;

  localparam int NS = `PJM_NUM_STAGE;

  pjm_state_t state_reg;
  logic [NS-1:0] sens;
  logic [NS-1:0] start;
  logic [NS-1:0] late;
  logic [NS-1:0] lag;
  logic [NS-1:0] sens_q;
  logic [NS-1:0] rise;
  logic [NS-1:0] fall;
  logic [`PJM_NUM_PATH-1:0] path_busy;
  logic running;
  logic door_open;
  logic ent_pending_reg;
  logic next_exit_reg;
  logic sheet_fed_miss;
  pjm_code_t code_next;
  logic fault;

  // Stage order: 0 ent, 1 siga, 2 sigb, 3 tim, 4 tray, 5 subgrip, 6 cpa, 7 cpb,
  // 8 hex, 9 reg, 10 reg after switchback, 11 small, 12 large, 13 inva, 14 invb,
  // 15 inserter transport (source only), 16 spare
  assign sens = {1'b0, inserter_transport_sensor, inserter_vertical_sensor_b,
                 inserter_vertical_sensor_a, cover_side_sensor_large,
                 cover_side_sensor_small, cover_registration_sensor,
                 cover_registration_sensor, horizontal_exit_sensor,
                 cover_path_sensor_b, cover_path_sensor_a, sub_grip_sheet_sensor,
                 tray_empty_sensor, timing_edge_sensor, signature_path_sensor_b,
                 signature_path_sensor_a, entrance_edge_sensor};
  assign path_busy = {cover_path_sensor_b, horizontal_exit_sensor,
                      cover_registration_sensor, cover_path_sensor_a,
                      signature_path_sensor_b, signature_path_sensor_a,
                      entrance_edge_sensor, tray_empty_sensor, timing_edge_sensor};
  assign rise = sens & ~sens_q;
  assign fall = ~sens & sens_q;
  assign running = (state_reg == PJM_ST_RUN);
  assign door_open = left_door_interlock | right_front_door_interlock;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sens_q <= '0;
    end else begin
      sens_q <= sens;
    end
  end

  always_comb begin
    start     = '0;
    start[0]  = sheet_exit;
    start[1]  = rise[0];
    start[2]  = rise[1];
    start[3]  = rise[2];
    start[4]  = rise[3];
    start[5]  = sub_grip_transfer;
    start[6]  = rise[0];
    start[7]  = rise[6];
    start[8]  = rise[7];
    start[9]  = rise[0];
    start[10] = switchback;
    start[11] = side_reg_small;
    start[12] = side_reg_large;
    start[13] = rise[15];
    start[14] = rise[13];
  end

  for (genvar g = 0; g < NS; g++) begin : g_stage
    pjm_edge_stage u_stage (
      .clock      (clock),
      .rst_n      (rst_n),
      .enable     (running),
      .start      (start[g]),
      .sensor     (sens[g]),
      .arrive_win (arrive_win[g]),
      .leave_win  (leave_win[g]),
      .late_jam   (late[g]),
      .lag_jam    (lag[g])
    );
  end

  // Entrance must report a sheet fed at its trailing edge, before the next sheet exit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ent_pending_reg <= 1'b0;
      sheet_fed       <= 1'b0;
    end else begin
      sheet_fed <= fall[0] & ent_pending_reg & running & ~next_exit_reg;
      if (rise[0]) begin
        ent_pending_reg <= 1'b1;
      end else if (fall[0]) begin
        ent_pending_reg <= 1'b0;
      end
    end
  end

  // Highest-priority cause picks the code
  always_comb begin
    code_next = `PJM_CODE_NONE;
    if (door_open || (top_cover_open_sensor && delivery_active)) begin
      code_next = `PJM_C_DOOR;
    end else if (job_load && job_sheets > `PJM_SHEETS_MAX) begin
      code_next = `PJM_C_OVERFLOW;
    end else if (job_load && job_sheets < `PJM_SHEETS_MIN) begin
      code_next = `PJM_C_TOO_FEW;
    end else if (job_load && job_trim_mm > `PJM_TRIM_MAX_MM) begin
      code_next = `PJM_C_TRIM_WIDE;
    end else if (job_load && job_length_mm > `PJM_LEN_MAX_MM) begin
      code_next = `PJM_C_BOOK_LONG;
    end else if (stacking_active && stacking_overflow_sensor) begin
      code_next = `PJM_C_OVERFLOW;
    end else if (size_mismatch) begin
      code_next = `PJM_C_SIZE;
    end else if (fall[0] && ent_pending_reg && sheet_fed_miss) begin
      code_next = `PJM_C_DOUBLE;
    end else if (late[0])  code_next = `PJM_C_ENT_LATE;
    else if (late[1])  code_next = `PJM_C_SIGA_LATE;
    else if (late[2])  code_next = `PJM_C_SIGB_LATE;
    else if (late[3])  code_next = `PJM_C_TIM_LATE;
    else if (late[4])  code_next = `PJM_C_TRAY_LATE;
    else if (late[5])  code_next = `PJM_C_SUBG_LATE;
    else if (late[6])  code_next = `PJM_C_CPA_LATE;
    else if (late[7])  code_next = `PJM_C_CPB_LATE;
    else if (late[8])  code_next = `PJM_C_HEX_LATE;
    else if (late[9])  code_next = `PJM_C_REG_LATE;
    else if (late[10]) code_next = `PJM_C_REGSW_LATE;
    else if (late[11]) code_next = `PJM_C_SMS_LATE;
    else if (late[12]) code_next = `PJM_C_SML_LATE;
    else if (late[13]) code_next = `PJM_C_INVA_LATE;
    else if (late[14]) code_next = `PJM_C_INVB_LATE;
    else if (lag[0])   code_next = `PJM_C_ENT_LAG;
    else if (lag[1])   code_next = `PJM_C_SIGA_LAG;
    else if (lag[2])   code_next = `PJM_C_SIGB_LAG;
    else if (lag[3])   code_next = `PJM_C_TIM_LAG;
    else if (lag[4] || lag[5]) code_next = `PJM_C_TRAY_LAG;
    else if (lag[6])   code_next = `PJM_C_CPA_LAG;
    else if (lag[7])   code_next = `PJM_C_CPB_LAG;
    else if (lag[8])   code_next = `PJM_C_HEX_LAG;
    else if (lag[9])   code_next = `PJM_C_REG_LAG;
    else if (lag[10])  code_next = `PJM_C_REGSW_LAG;
    else if (lag[11])  code_next = `PJM_C_SMS_LAG;
    else if (lag[12])  code_next = `PJM_C_SML_LAG;
    else if (lag[13])  code_next = `PJM_C_INVA_LAG;
    else if (lag[14])  code_next = `PJM_C_INVB_LAG;
  end

  // Next exit while entrance still covered: coming trailing edge is not ours
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      next_exit_reg <= 1'b0;
    end else if (sheet_exit && ent_pending_reg && !fall[0]) begin
      next_exit_reg <= 1'b1;
    end else if (fall[0] || !running) begin
      next_exit_reg <= 1'b0;
    end
  end
  assign sheet_fed_miss = next_exit_reg;
  assign fault = (code_next != `PJM_CODE_NONE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= PJM_ST_POWERUP;
      jam_code    <= `PJM_CODE_NONE;
      jam_valid   <= 1'b0;
      binder_halt <= 1'b1;
    end else begin
      jam_valid <= 1'b0;
      case (state_reg)
        PJM_ST_POWERUP: begin
          if (|path_busy) begin
            jam_code  <= `PJM_C_POWERON;
            jam_valid <= 1'b1;
            state_reg <= PJM_ST_HALT;
          end else begin
            binder_halt <= 1'b0;
            state_reg   <= PJM_ST_RUN;
          end
        end
        PJM_ST_RUN: begin
          if (fault) begin
            jam_code    <= code_next;
            jam_valid   <= 1'b1;
            binder_halt <= 1'b1;
            state_reg   <= PJM_ST_HALT;
          end
        end
        PJM_ST_HALT: begin
          if (jam_clear && !door_open && !top_cover_open_sensor) begin
            state_reg <= PJM_ST_RECHECK;
          end
        end
        PJM_ST_RECHECK: begin
          if (|path_busy) begin
            jam_code  <= `PJM_C_RESIDUE;
            jam_valid <= 1'b1;
            state_reg <= PJM_ST_HALT;
          end else begin
            jam_code    <= `PJM_CODE_NONE;
            binder_halt <= 1'b0;
            state_reg   <= PJM_ST_RUN;
          end
        end
        default: begin
          state_reg   <= PJM_ST_HALT;
          binder_halt <= 1'b1;
        end
      endcase
    end
  end

  halt_on_jam_a: assert property (@(posedge clock) disable iff (!rst_n)
    (running && fault) |=> (binder_halt && jam_valid && jam_code == $past(code_next)))
    else $error("jam did not halt and report");
  door_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    (running && door_open) |=> (jam_code == 16'h1400))
    else $error("door open not coded");
  few_sheets_a: assert property (@(posedge clock) disable iff (!rst_n)
    (running && !door_open && !(top_cover_open_sensor && delivery_active) && job_load
     && job_sheets < 8'd9) |=> (jam_code == 16'h1FA1))
    else $error("short job not rejected");
  power_on_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == PJM_ST_POWERUP && |path_busy) |=> (jam_code == 16'h1300 && binder_halt))
    else $error("power-on residue missed");
  residue_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == PJM_ST_RECHECK && |path_busy) |=> (jam_code == 16'h1700))
    else $error("residue after close missed");
  halt_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == PJM_ST_HALT) |-> binder_halt)
    else $error("halted state not halting");
  ent_late_a: assert property (@(posedge clock) disable iff (!rst_n)
    (running && late[0] && code_next == `PJM_C_ENT_LATE) |=> jam_code == 16'h1011)
    else $error("entrance late code wrong");
  size_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (running && size_mismatch) |=> binder_halt)
    else $error("size mismatch not stopped");
endmodule // pjm_jam_monitor

//--- dv/pjm_host_model.sv
// Host machine model: sends sheets and collects jam reports
`timescale 1ns/1ps
module pjm_host_model (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire pjm_pkg::pjm_code_t jam_code,
  input  wire logic               jam_valid,
  input  wire logic               binder_halt,
  input  wire logic               sheet_fed,
  output logic                    sheet_exit
);
  import pjm_pkg::*;
  int        n_jams;
  int        n_fed;
  pjm_code_t last_code;
  initial sheet_exit = 1'b0;
  // One-cycle exit pulse, launched off the falling edge
  task automatic send_sheet();
    @(negedge clock);
    sheet_exit = 1'b1;
    @(negedge clock);
    sheet_exit = 1'b0;
  endtask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      n_jams    <= 0;
      n_fed     <= 0;
      last_code <= 16'h0000;
    end else begin
      if (jam_valid === 1'b1) begin
        n_jams    <= n_jams + 1;
        last_code <= jam_code;
      end
      if (sheet_fed === 1'b1) begin
        n_fed <= n_fed + 1;
      end
    end
  end
endmodule // pjm_host_model

//--- dv/pjm_jam_monitor_test.sv
// Self-checking bench for the paper path jam monitor
`timescale 1ns/1ps
`include "pjm_regs.svh"
module pjm_jam_monitor_test;
  import pjm_pkg::*;
  localparam pjm_win_t BIG = 16'h1000;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        sheet_exit;
  logic [15:0] sens = 16'h0000;
  logic [3:0]  trig = 4'h0;
  logic [2:0]  door = 3'h0;
  logic        delivery_active = 1'b0;
  logic        stacking_active = 1'b0;
  logic        stacking_overflow_sensor = 1'b0;
  logic        size_mismatch = 1'b0;
  logic        jam_clear = 1'b0;
  logic        job_load = 1'b0;
  logic [7:0]  job_sheets = 8'h09;
  logic [7:0]  job_trim_mm = 8'h00;
  logic [8:0]  job_length_mm = 9'h000;
  pjm_win_t    arrive_win [`PJM_NUM_STAGE];
  pjm_win_t    leave_win [`PJM_NUM_STAGE];
  pjm_code_t   jam_code;
  logic        jam_valid;
  logic        binder_halt;
  logic        sheet_fed;
  logic [31:0] seed = 32'h4CC7079B;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_fed0;
  int          nine [9] = '{0, 1, 2, 3, 4, 6, 7, 8, 9};

  always #5 clock = ~clock;

  pjm_jam_monitor i_pjm_jam_monitor (
    .clock, .rst_n, .sheet_exit,
    .entrance_edge_sensor(sens[0]), .signature_path_sensor_a(sens[1]),
    .signature_path_sensor_b(sens[2]), .timing_edge_sensor(sens[3]),
    .tray_empty_sensor(sens[4]), .sub_grip_transfer(trig[0]),
    .sub_grip_sheet_sensor(sens[5]), .cover_path_sensor_a(sens[6]),
    .cover_path_sensor_b(sens[7]), .horizontal_exit_sensor(sens[8]),
    .cover_registration_sensor(sens[9]), .switchback(trig[1]),
    .side_reg_small(trig[2]), .side_reg_large(trig[3]),
    .cover_side_sensor_small(sens[11]), .cover_side_sensor_large(sens[12]),
    .inserter_transport_sensor(sens[15]), .inserter_vertical_sensor_a(sens[13]),
    .inserter_vertical_sensor_b(sens[14]), .top_cover_open_sensor(door[0]),
    .delivery_active, .left_door_interlock(door[1]),
    .right_front_door_interlock(door[2]), .stacking_active,
    .stacking_overflow_sensor, .job_load, .job_sheets, .job_trim_mm,
    .job_length_mm, .size_mismatch, .jam_clear, .arrive_win, .leave_win,
    .jam_code, .jam_valid, .binder_halt, .sheet_fed);

  pjm_host_model i_pjm_host_model (
    .clock, .rst_n, .jam_code, .jam_valid, .binder_halt, .sheet_fed, .sheet_exit);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Waits for a new jam report and checks its code and delay
  task automatic wait_jam(input pjm_code_t exp, input int lo, input int hi);
    int n0;
    int n;
    n0 = i_pjm_host_model.n_jams;
    n = 0;
    while (i_pjm_host_model.n_jams == n0 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    check({15'h0, n >= lo && n <= hi}, 16'h0001, "jam delay");
    check(i_pjm_host_model.last_code, exp, "jam code");
    check({15'h0, binder_halt}, 16'h0001, "binder halt");
  endtask

  task automatic quiet(input string what);
    int n0;
    n0 = i_pjm_host_model.n_jams;
    repeat (20) @(negedge clock);
    check(16'(i_pjm_host_model.n_jams - n0), 16'h0000, what);
  endtask

  // Clears every cause, then asks the monitor to resume
  task automatic recover();
    sens = 16'h0000;
    door = 3'h0;
    trig = 4'h0;
    {size_mismatch, stacking_overflow_sensor, delivery_active, stacking_active} = 4'h0;
    repeat (2) @(negedge clock);
    jam_clear = 1'b1;
    @(negedge clock);
    jam_clear = 1'b0;
    for (int i = 0; i < 50 && binder_halt !== 1'b0; i++) @(negedge clock);
    check({15'h0, binder_halt}, 16'h0000, "resume");
  endtask

  // tg: 0 sheet exit, 1..4 trig bit, 5 none; m: sensors raised in path order
  task automatic run_case(input int st, input int tg, input logic [15:0] m,
                          input pjm_code_t exp, input bit lag);
    pjm_win_t w;
    int j;
    w = 16'h0004 + pjm_win_t'(rnd() & 32'h3F);
    arrive_win = '{default: BIG};
    leave_win = '{default: BIG};
    if (lag) leave_win[st] = w;
    else arrive_win[st] = w;
    recover();
    if (tg == 0) i_pjm_host_model.send_sheet();
    else if (tg < 5) begin
      trig[tg-1] = 1'b1;
      @(negedge clock);
      trig = 4'h0;
    end
    for (int k = 0; k < 16; k++) begin
      j = (k + 15) % 16;
      if (m[j]) begin
        sens[j] = 1'b1;
        repeat (3) @(negedge clock);
      end
    end
    wait_jam(exp, int'(w) - 4, int'(w) + 6);
  endtask

  initial begin
    arrive_win = '{default: BIG};
    leave_win = '{default: BIG};
    sens[nine[rnd() % 9]] = 1'b1;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check(jam_code, 16'h1300, "power-on code");
    check({15'h0, binder_halt}, 16'h0001, "power-on halt");
    jam_clear = 1'b1;
    @(negedge clock);
    jam_clear = 1'b0;
    repeat (10) @(negedge clock);
    check(jam_code, 16'h1700, "residue code");
    recover();
    $display("done: power-on and residue");
    run_case(0, 0, 16'h0000, 16'h1011, 0);
    run_case(1, 0, 16'h0001, 16'h1012, 0);
    run_case(2, 0, 16'h0003, 16'h1013, 0);
    run_case(3, 0, 16'h0007, 16'h1014, 0);
    run_case(4, 0, 16'h000F, 16'h1015, 0);
    run_case(5, 1, 16'h0000, 16'h1016, 0);
    run_case(6, 0, 16'h0001, 16'h1017, 0);
    run_case(7, 0, 16'h0041, 16'h1018, 0);
    run_case(8, 0, 16'h00C1, 16'h1019, 0);
    run_case(9, 0, 16'h0001, 16'h101A, 0);
    run_case(10, 2, 16'h0000, 16'h101B, 0);
    run_case(11, 3, 16'h0000, 16'h101C, 0);
    run_case(12, 4, 16'h0000, 16'h101D, 0);
    run_case(13, 5, 16'h8000, 16'h1068, 0);
    run_case(14, 5, 16'hA000, 16'h106A, 0);
    $display("done: late jams");
    run_case(0, 0, 16'h0001, 16'h1121, 1);
    run_case(1, 0, 16'h0003, 16'h1122, 1);
    run_case(2, 0, 16'h0007, 16'h1123, 1);
    run_case(3, 0, 16'h000F, 16'h1124, 1);
    run_case(5, 1, 16'h0020, 16'h1125, 1);
    run_case(6, 0, 16'h0041, 16'h1127, 1);
    run_case(7, 0, 16'h00C1, 16'h1128, 1);
    run_case(8, 0, 16'h01C1, 16'h1129, 1);
    run_case(9, 0, 16'h0201, 16'h112A, 1);
    run_case(10, 2, 16'h0200, 16'h112B, 1);
    run_case(11, 3, 16'h0800, 16'h112C, 1);
    run_case(12, 4, 16'h1000, 16'h112D, 1);
    run_case(13, 5, 16'hA000, 16'h1169, 1);
    run_case(14, 5, 16'hE000, 16'h116B, 1);
    $display("done: lag jams");
    recover();
    n_fed0 = i_pjm_host_model.n_fed;
    arrive_win = '{default: BIG};
    i_pjm_host_model.send_sheet();
    sens[0] = 1'b1;
    repeat (3) @(negedge clock);
    sens[0] = 1'b0;
    repeat (8) @(negedge clock);
    check(16'(i_pjm_host_model.n_fed - n_fed0), 16'h0001, "sheet fed");
    i_pjm_host_model.send_sheet();
    sens[0] = 1'b1;
    repeat (3) @(negedge clock);
    i_pjm_host_model.send_sheet();
    sens[0] = 1'b0;
    wait_jam(16'h1200, 0, 20);
    recover();
    door[0] = 1'b1;
    quiet("top cover idle");
    for (int i = 0; i < 3; i++) begin
      delivery_active = 1'b1;
      door[i] = 1'b1;
      wait_jam(16'h1400, 0, 20);
      recover();
    end
    stacking_overflow_sensor = 1'b1;
    quiet("overflow idle");
    stacking_active = 1'b1;
    wait_jam(16'h1FA0, 0, 20);
    recover();
    size_mismatch = 1'b1;
    wait_jam(16'h1FA5, 0, 20);
    recover();
    $display("done: interlocks and sensors");
    job(8'd201, 8'd0, 9'd0);
    wait_jam(16'h1FA0, 0, 20);
    recover();
    job(8'd8, 8'd0, 9'd0);
    wait_jam(16'h1FA1, 0, 20);
    recover();
    job(8'd9, 8'd41, 9'd0);
    wait_jam(16'h1FA2, 0, 20);
    recover();
    job(8'd9, 8'd40, 9'd217);
    wait_jam(16'h1FA3, 0, 20);
    recover();
    job(8'd200, 8'd40, 9'd216);
    quiet("job limits");
    for (int i = 0; i < 8; i++) begin
      job(8'(9 + rnd() % 192), 8'(rnd() % 41), 9'(rnd() % 217));
      quiet("random job");
    end
    $display("done: job limits");
    finish_test();
  end

  task automatic job(input logic [7:0] s, input logic [7:0] t, input logic [8:0] l);
    job_sheets = s;
    job_trim_mm = t;
    job_length_mm = l;
    job_load = 1'b1;
    @(negedge clock);
    job_load = 1'b0;
  endtask

  initial begin
    // Roughly ten times the expected run length
    #200_000;
    n_fail++;
    finish_test();
  end
endmodule // pjm_jam_monitor_test
